/* File: jrls_pkg.sv */
`default_nettype none
package jrls_pkg;
  localparam int NUM_LANES = 8;
  localparam logic [11:0] FRAME_LOCK_ADDR = 12'h471;
  localparam logic [11:0] SUM_OK_ADDR = 12'h472;
  localparam logic [11:0] LINK_CTRL_ADDR = 12'h475;
  localparam logic [11:0] OPTION_ADDR = 12'h476;
  localparam int SUBST_OFF_BIT = 6;
  localparam int SKIP_ILAS_BIT = 7;
  localparam int CORE_RESET_BIT = 3;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  // JESD204B control characters
  localparam logic [7:0] CHAR_A = 8'h7c;
  localparam logic [7:0] CHAR_F = 8'hfc;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } jrls_cfg_req_type;

  typedef struct packed {
    logic [7:0] data;
    logic is_k;
  } jrls_octet_type;
endpackage
`default_nettype wire

/* File: jrls_lane_status.sv */
`default_nettype none
module jrls_lane_status
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire jrls_pkg::jrls_cfg_req_type i_cfg,
  output logic [7:0] o_cfg_rdata,
  input wire logic [7:0] i_frame_aligned,
  input wire logic [7:0] i_sum_valid,
  input wire logic [7:0] i_sum_match,
  input wire jrls_pkg::jrls_octet_type [7:0] i_lane_octet,
  input wire logic [7:0] i_frame_end,
  input wire logic [7:0] i_mframe_end,
  output jrls_pkg::jrls_octet_type [7:0] o_lane_octet,
  output logic o_core_in_reset,
  output logic o_skip_lane_alignment_seq
);
  import jrls_pkg::*;

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic addr_hit(input jrls_cfg_req_type req,
                                    input logic [11:0] addr);
    return req.addr == addr;
  endfunction

  logic hit_lock;
  logic hit_sum;
  logic hit_ctrl;
  logic hit_option;
  logic rd_req;
  logic wr_req;

  assign rd_req = i_cfg.rd;
  assign wr_req = i_cfg.wr;
  assign hit_lock = addr_hit(i_cfg, FRAME_LOCK_ADDR);
  assign hit_sum = addr_hit(i_cfg, SUM_OK_ADDR);
  assign hit_ctrl = addr_hit(i_cfg, LINK_CTRL_ADDR);
  assign hit_option = addr_hit(i_cfg, OPTION_ADDR);

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0] frame_locked_q;
  logic [7:0] frame_locked_d;
  logic [7:0] sum_ok_q;
  logic [7:0] sum_ok_d;
  logic [7:0] ctrl_q;
  logic [7:0] option_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic wr_ctrl;
  logic wr_option;
  logic end_char_subst_off;
  logic core_rst;

  // Write strobes
  assign wr_ctrl = wr_req && hit_ctrl;
  assign wr_option = wr_req && hit_option;

  // Control fields
  assign end_char_subst_off = option_q[SUBST_OFF_BIT];
  assign core_rst = ctrl_q[CORE_RESET_BIT];

  // Core soft reset and the rest of the link control byte
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      ctrl_q <= CTRL_RESET;
    else if (wr_ctrl)
      ctrl_q <= i_cfg.wdata;
  end

  // Option bits, meant to change only under core reset; a write to OPTION_ADDR is taken whether or not core_rst is set
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      option_q <= OPTION_RESET;
    else if (wr_option)
      option_q <= i_cfg.wdata;
  end

  // ****************************************
  // Lane status
  // ****************************************
  // Frame lock follows the aligner; cleared under core reset
  assign frame_locked_d = core_rst ? STATUS_RESET : i_frame_aligned;

  // Checksum bit follows each new evaluation, held otherwise; cleared under core reset
  always_comb
  begin
    sum_ok_d = sum_ok_q;
    for (int n = 0; n < NUM_LANES; n++)
    begin
      if (i_sum_valid[n])
        sum_ok_d[n] = i_sum_match[n];
    end
    if (core_rst)
      sum_ok_d = STATUS_RESET;
  end

  // Status bits have no write path
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      frame_locked_q <= STATUS_RESET;
    else
      frame_locked_q <= frame_locked_d;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      sum_ok_q <= STATUS_RESET;
    else
      sum_ok_q <= sum_ok_d;
  end

  // ****************************************
  // Register read
  // ****************************************
  logic [7:0] rd_lock_v;
  logic [7:0] rd_sum_v;
  logic [7:0] rd_ctrl_v;
  logic [7:0] rd_option_v;

  // Addresses are distinct, so the sources merge by OR
  assign rd_lock_v = hit_lock ? frame_locked_q : 8'h00;
  assign rd_sum_v = hit_sum ? sum_ok_q : 8'h00;
  assign rd_ctrl_v = hit_ctrl ? ctrl_q : 8'h00;
  assign rd_option_v = hit_option ? option_q : 8'h00;
  assign rdata_d = rd_lock_v | rd_sum_v | rd_ctrl_v | rd_option_v;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rdata_q <= STATUS_RESET;
    else if (rd_req)
      rdata_q <= rdata_d;
  end

  assign o_cfg_rdata = rdata_q;

  // ****************************************
  // End-of-frame character substitution
  // ****************************************
  // Alignment character at the boundary that it marks
  function automatic logic end_char_hit(input jrls_octet_type oct,
                                        input logic fend,
                                        input logic mfend);
    logic hit_a;
    logic hit_f;
    hit_a = mfend && (oct.data == CHAR_A);
    hit_f = fend && (oct.data == CHAR_F);
    return oct.is_k && (hit_a || hit_f);
  endfunction

  jrls_octet_type [7:0] lane_d;
  jrls_octet_type [7:0] lane_q;
  logic [7:0] lane_hit;
  logic [7:0] last_q;

  // Per-lane replacement request, dropped when disabled
  always_comb
  begin
    for (int n = 0; n < NUM_LANES; n++)
    begin
      lane_hit[n] = !end_char_subst_off &&
                    end_char_hit(i_lane_octet[n], i_frame_end[n],
                                 i_mframe_end[n]);
    end
  end

  // Replacement repeats the lane's previous data octet
  always_comb
  begin
    lane_d = i_lane_octet;
    for (int n = 0; n < NUM_LANES; n++)
    begin
      if (lane_hit[n])
      begin
        lane_d[n].data = last_q[n] ? lane_q[n].data : 8'h00;
        lane_d[n].is_k = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      lane_q <= '0;
    else
      lane_q <= lane_d;
  end

  // Marks that a lane has produced an octet since reset
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      last_q <= 8'h00;
    else
      last_q <= 8'hff;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_lane_octet = lane_q;
  assign o_core_in_reset = core_rst;
  assign o_skip_lane_alignment_seq = option_q[SKIP_ILAS_BIT];
endmodule
`default_nettype wire

/* File: jrls_chk.sv */
`default_nettype none
module jrls_chk
  import jrls_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire jrls_cfg_req_type i_cfg,
  input wire logic [7:0] o_cfg_rdata,
  input wire logic [7:0] i_frame_aligned,
  input wire logic [7:0] i_sum_valid,
  input wire logic [7:0] i_sum_match,
  input wire jrls_octet_type [7:0] i_lane_octet,
  input wire logic [7:0] i_frame_end,
  input wire logic [7:0] i_mframe_end,
  input wire jrls_octet_type [7:0] o_lane_octet,
  input wire logic o_core_in_reset
);
  logic off_q, core_q;
  wire rdl = i_cfg.rd && i_cfg.addr == FRAME_LOCK_ADDR;
  wire rds = i_cfg.rd && i_cfg.addr == SUM_OK_ADDR;
  wire ka = i_lane_octet[0] == {CHAR_A, 1'b1} && i_mframe_end[0];
  wire kf = i_lane_octet[0] == {CHAR_F, 1'b1} && i_frame_end[0];
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      {off_q, core_q} <= 2'b00;
    else
    begin
      core_q <= o_core_in_reset;
      if (i_cfg.wr && i_cfg.addr == OPTION_ADDR)
        off_q <= i_cfg.wdata[SUBST_OFF_BIT];
    end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  property p_lock;
    rdl && !core_q |=> o_cfg_rdata == $past(i_frame_aligned, 2);
  endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_sum;
    rds && !core_q |=> (o_cfg_rdata & $past(i_sum_valid, 2)) ==
      $past(i_sum_match & i_sum_valid, 2);
  endproperty
  a_sum: assert property (p_sum) else $error("sum");
  property p_zero;
    rds && core_q |=> o_cfg_rdata == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("zero");
  property p_off;
    off_q |=> o_lane_octet == $past(i_lane_octet);
  endproperty
  a_off: assert property (p_off) else $error("off");
  property p_sub;
    !off_q && ka |=> o_lane_octet[0] == {$past(o_lane_octet[0].data), 1'b0};
  endproperty
  a_sub: assert property (p_sub) else $error("sub");
  property p_subf;
    !off_q && kf |=> o_lane_octet[0] == {$past(o_lane_octet[0].data), 1'b0};
  endproperty
  a_subf: assert property (p_subf) else $error("subf");
  property p_pass;
    !off_q && !i_lane_octet[0].is_k |=>
      o_lane_octet[0] == $past(i_lane_octet[0]);
  endproperty
  a_pass: assert property (p_pass) else $error("pass");
  c_lock: cover property (rdl);
  c_sub: cover property (!off_q && ka);
  c_off: cover property (off_q);
endmodule
bind jrls_lane_status jrls_chk chk (.*);
`default_nettype wire

/* File: jrls_tx.sv */
`default_nettype none
module jrls_tx
  import jrls_pkg::*;
(
  input wire logic [8:0] i_oct,
  output logic [7:0][8:0] o_oct
);
  // Same octet on every lane
  assign o_oct = {8{i_oct}};
endmodule
`default_nettype wire

/* File: tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import jrls_pkg::*;
  logic i_clk = 0, i_nrst = 0, o_core_in_reset, o_skip_lane_alignment_seq;
  jrls_cfg_req_type i_cfg = '0;
  logic [7:0] o_cfg_rdata, i_frame_aligned = '0, i_sum_valid = '0;
  logic [7:0] i_sum_match = '0, i_frame_end = '0, i_mframe_end = '0;
  logic [8:0] oct = '0;
  jrls_octet_type [7:0] i_lane_octet, o_lane_octet;
  int miscompares = 0, check_count = 0, cyc = 0;
  jrls_tx tx (.i_oct(oct), .o_oct(i_lane_octet));
  jrls_lane_status uut (.*);
  initial forever #2.5 i_clk = ~i_clk;
  task automatic chk(string n, logic [8:0] e, logic [8:0] s);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(posedge i_clk) i_cfg <= {2'b10, a, d};
    @(posedge i_clk) i_cfg <= '0;
  endtask
  task automatic rd(logic [11:0] a, logic [7:0] e);
    @(posedge i_clk) i_cfg <= {2'b01, a, 8'h00};
    @(posedge i_clk) i_cfg <= '0;
    @(negedge i_clk) chk("rdata", {1'b0, e}, {1'b0, o_cfg_rdata});
  endtask
  task automatic ln(logic [8:0] x, logic [1:0] fm, logic [8:0] e);
    @(posedge i_clk) oct <= x;
    i_frame_end <= {8{fm[1]}};
    i_mframe_end <= {8{fm[0]}};
    @(posedge i_clk);
    @(negedge i_clk) chk("lane", e, o_lane_octet[5]);
  endtask
  task automatic t_status;
    rd(FRAME_LOCK_ADDR, 8'h00);
    rd(SUM_OK_ADDR, 8'h00);
    @(posedge i_clk) i_frame_aligned <= 8'ha5;
    i_sum_valid <= 8'hff;
    i_sum_match <= 8'h3c;
    rd(SUM_OK_ADDR, 8'h3c);
    @(posedge i_clk) i_sum_valid <= 8'h00;
    rd(FRAME_LOCK_ADDR, 8'ha5);
    wr(SUM_OK_ADDR, 8'hff);
    wr(FRAME_LOCK_ADDR, 8'h00);
    rd(SUM_OK_ADDR, 8'h3c);
    @(posedge i_clk) i_frame_aligned <= 8'h0f;
    rd(FRAME_LOCK_ADDR, 8'h0f);
  endtask
  task automatic t_subst;
    wr(LINK_CTRL_ADDR, 8'h08);
    @(negedge i_clk) chk("core", 9'h001, 9'(o_core_in_reset));
    rd(SUM_OK_ADDR, 8'h00);
    wr(LINK_CTRL_ADDR, 8'h00);
    ln(9'h022, 2'b00, 9'h022);
    ln({CHAR_F, 1'b1}, 2'b10, 9'h022);
    ln({CHAR_A, 1'b1}, 2'b01, 9'h022);
    wr(LINK_CTRL_ADDR, 8'h08);
    wr(OPTION_ADDR, 8'h40);
    wr(LINK_CTRL_ADDR, 8'h00);
    ln({CHAR_F, 1'b1}, 2'b10, {CHAR_F, 1'b1});
    ln({CHAR_A, 1'b1}, 2'b01, {CHAR_A, 1'b1});
    wr(LINK_CTRL_ADDR, 8'h08);
    wr(OPTION_ADDR, 8'hc0);
    wr(LINK_CTRL_ADDR, 8'h00);
    @(negedge i_clk) chk("skip", 9'h001, 9'(o_skip_lane_alignment_seq));
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge i_clk)
    if (++cyc == 500)
    begin
      miscompares++;
      end_of_test;
    end
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_status;
    t_subst;
    end_of_test;
  end
endmodule
`default_nettype wire
